/* File: rtl/wps_top.sv */
/*
  Waveform playback sequencer: register slave, trigger sources, sequence engine,
  waveform and sequence memories, and the output buffer toward the converter.
  Assumes one 200 MHz clock, an Avalon-MM master, and a converter that takes
  four samples per clock and may stall through quad_ready_i.
*/
`timescale 1ns/1ps
`include "wps_defs.svh"
module wps_top (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [7:0]        address_i,
  input  wire logic              read_i,
  input  wire logic              write_i,
  input  wire logic [3:0]        byteenable_i,
  input  wire logic [31:0]       writedata_i,
  output logic      [31:0]       readdata_o,
  output logic                   waitrequest_o,
  input  wire logic              trig_pin_i,
  input  wire logic              trig_btn_i,
  input  wire logic              gate_i,
  input  wire logic              event_i,
  input  wire logic              mem_opt_i,
  output wps_pkg::wps_quad_t     quad_o,
  output logic                   quad_valid_o,
  input  wire logic              quad_ready_i,
  output logic                   dclk_o
);
  localparam int QW = $bits(wps_pkg::wps_quad_t);
  localparam int SW = $bits(wps_pkg::wps_step_t);

  function automatic logic len_ok(input logic [31:0] pts, input logic opt);
    len_ok = (pts[1:0] == 2'h0) && (pts[31:25] == 7'h00)
          && (pts[24:0] >= `WPS_PTS_MIN)
          && (pts[24:0] <= (opt ? `WPS_PTS_OPT : `WPS_PTS_BASE));
  endfunction

  // Pin synchronisers: a level counts once stages two and three agree
  logic [`WPS_NPIN-1:0] s1_q, s2_q, s3_q, lvl_q;
  wire  [`WPS_NPIN-1:0] lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
  wire  [`WPS_NPIN-1:0] rise  = lvl_d & ~lvl_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= {mem_opt_i, event_i, gate_i, trig_btn_i, trig_pin_i};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // Register slave: request answered on its second cycle
  logic        ack_q, err_q, cmd_trig_q, run_q, itrg_q;
  logic [1:0]  mode_q;
  logic [26:0] per_q;
  logic [12:0] scnt_q, sidx_q;
  logic [22:0] ssta_q, slen_q, wadr_q;
  logic [7:0]  mdat_q;
  wps_pkg::wps_state_t st_q, st_d;
  logic [12:0] step_q, step_d;

  wire req   = read_i | write_i;
  wire wr    = write_i & ack_q & (byteenable_i == 4'hF);
  wire opt   = lvl_q[`WPS_P_OPT];
  wire w_ctl = wr && address_i == `WPS_A_CTRL;
  wire w_st  = wr && address_i == `WPS_A_STAT;
  wire w_cmd = wr && address_i == `WPS_A_CMD;
  wire w_per = wr && address_i == `WPS_A_PER;
  wire w_cnt = wr && address_i == `WPS_A_SCNT;
  wire w_idx = wr && address_i == `WPS_A_SIDX;
  wire w_sta = wr && address_i == `WPS_A_SSTA;
  wire w_len = wr && address_i == `WPS_A_SLEN;
  wire w_sct = wr && address_i == `WPS_A_SCTL;
  wire w_adr = wr && address_i == `WPS_A_WADR;
  wire w_mdt = wr && address_i == `WPS_A_MDAT;
  wire w_sdt = wr && address_i == `WPS_A_SDAT;
  wire per_ok = (writedata_i[31:27] == 5'h00) && (writedata_i[26:0] >= `WPS_PER_MIN)
             && (writedata_i[26:0] <= `WPS_PER_MAX);
  wire len_good = len_ok(writedata_i, opt);
  wire bad_set  = (w_len && !len_good) || (w_per && !per_ok);
  wire wmem_ok  = wadr_q < (opt ? `WPS_Q_OPT : `WPS_Q_BASE);

  wire [31:0] rd_mux =
      (address_i == `WPS_A_CTRL) ? {28'h000_0000, itrg_q, run_q, mode_q} :
      (address_i == `WPS_A_STAT) ? {3'h0, step_q, 12'h000, opt, err_q,
                                    st_q == wps_pkg::ST_WAIT, st_q != wps_pkg::ST_IDLE} :
      (address_i == `WPS_A_PER)  ? {5'h00, per_q} :
      (address_i == `WPS_A_SCNT) ? {19'h0_0000, scnt_q} :
      (address_i == `WPS_A_SIDX) ? {19'h0_0000, sidx_q} :
      (address_i == `WPS_A_SSTA) ? {9'h000, ssta_q} :
      (address_i == `WPS_A_SLEN) ? {7'h00, slen_q, 2'h0} :
      (address_i == `WPS_A_WADR) ? {9'h000, wadr_q} :
      (address_i == `WPS_A_MDAT) ? {24'h00_0000, mdat_q} : 32'h0000_0000;

  assign waitrequest_o = req & ~ack_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q      <= 1'b0;
      readdata_o <= 32'h0000_0000;
      err_q      <= 1'b0;
      cmd_trig_q <= 1'b0;
    end else begin
      ack_q      <= req & ~ack_q;
      readdata_o <= rd_mux;
      err_q      <= bad_set | (err_q & ~(w_st & writedata_i[`WPS_S_ERR]));
      cmd_trig_q <= w_cmd & writedata_i[`WPS_K_TRIG];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= 2'h0;
      run_q  <= 1'b0;
      itrg_q <= 1'b0;
      per_q  <= `WPS_PER_RST;
      scnt_q <= `WPS_SEQ_CNT_RST;
      sidx_q <= 13'h0000;
      ssta_q <= 23'h00_0000;
      slen_q <= 23'h00_0000;
      wadr_q <= 23'h00_0000;
      mdat_q <= 8'h00;
    end else begin
      if (w_ctl) {itrg_q, run_q, mode_q} <= writedata_i[3:0];
      if (w_per && per_ok) per_q <= writedata_i[26:0];
      if (w_cnt) scnt_q <= writedata_i[12:0];
      if (w_idx) sidx_q <= writedata_i[12:0];
      else if (w_sct) sidx_q <= sidx_q + 13'h0001;
      if (w_sta) ssta_q <= writedata_i[22:0];
      if (w_len && len_good) slen_q <= writedata_i[24:2];
      if (w_adr) wadr_q <= writedata_i[22:0];
      else if (w_sdt) wadr_q <= wadr_q + 23'h00_0001;
      if (w_mdt) mdat_q <= writedata_i[7:0];
    end
  end

  // Internal trigger timer, counted in 0.1 us ticks
  logic [4:0]  tick_q;
  logic [26:0] pcnt_q;
  wire tick     = tick_q == 5'(`WPS_TICK_CYC - 1);
  wire tmr_trig = itrg_q && tick && (pcnt_q >= per_q - 27'h000_0001);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_q <= 5'h00;
      pcnt_q <= 27'h000_0000;
    end else begin
      tick_q <= (tick || !itrg_q) ? 5'h00 : tick_q + 5'h01;
      pcnt_q <= (tmr_trig || !itrg_q) ? 27'h000_0000 : pcnt_q + {26'h000_0000, tick};
    end
  end

  // Sequence engine
  wps_pkg::wps_mode_t mode;
  wps_pkg::wps_step_t ent_q, ent_d, seq_rd, seq_wr;
  logic [22:0] addr_q, addr_d, left_q, left_d;
  logic [15:0] rep_q, rep_d;
  logic        evt_q, evt_d, infl_q, flush, bufrdy, pop;
  logic [1:0]  bcnt;
  wps_pkg::wps_quad_t rd_quad;

  assign mode = wps_pkg::wps_mode_t'(mode_q);
  wire trig     = rise[`WPS_P_TRIG] | rise[`WPS_P_BTN] | cmd_trig_q | tmr_trig;
  wire gate     = lvl_q[`WPS_P_GATE];
  wire ext_ok   = mode == wps_pkg::WPS_ENH;
  wire stop     = !run_q || (mode == wps_pkg::WPS_GATE && !gate);
  wire [1:0] occ = bcnt + {1'b0, infl_q} - {1'b0, pop};
  wire issue    = st_q == wps_pkg::ST_PLAY && !stop && bufrdy && occ < 2'h2;
  wire pass_end = issue && left_q == 23'h00_0001;
  wire jump     = ext_ok && ent_q.jmp && (evt_q | rise[`WPS_P_EVT]);
  wire rep_done = !ent_q.inf && rep_q == 16'h0000;
  wire [12:0] nxt = jump ? ent_q.tgt : step_q + 13'h0001;
  wire wrap     = nxt >= scnt_q;
  wire once     = mode == wps_pkg::WPS_TRIG && wrap && !jump;

  always_comb begin
    st_d   = st_q;
    step_d = step_q;
    addr_d = addr_q;
    left_d = left_q;
    rep_d  = rep_q;
    ent_d  = ent_q;
    evt_d  = evt_q | (rise[`WPS_P_EVT] & st_q == wps_pkg::ST_PLAY);
    flush  = 1'b0;
    if (stop && st_q != wps_pkg::ST_IDLE) begin
      st_d  = wps_pkg::ST_IDLE;
      flush = 1'b1;
    end else begin
      unique case (st_q)
        wps_pkg::ST_IDLE: begin
          // Triggers arrive only here or in WAIT; during play they fall away
          if (!stop && (mode == wps_pkg::WPS_TRIG ? trig : 1'b1)) begin
            step_d = 13'h0000;
            st_d   = wps_pkg::ST_LOAD;
          end
        end
        wps_pkg::ST_LOAD: begin
          st_d = wps_pkg::ST_ARM;
        end
        wps_pkg::ST_ARM: begin
          ent_d  = seq_rd;
          addr_d = seq_rd.start;
          left_d = seq_rd.len;
          rep_d  = seq_rd.rep;
          evt_d  = 1'b0;
          st_d   = (ext_ok && seq_rd.wt) ? wps_pkg::ST_WAIT : wps_pkg::ST_PLAY;
        end
        wps_pkg::ST_WAIT: begin
          if (trig) begin
            st_d = wps_pkg::ST_PLAY;
          end
        end
        wps_pkg::ST_PLAY: begin
          if (issue) begin
            addr_d = addr_q + 23'h00_0001;
            left_d = left_q - 23'h00_0001;
          end
          if (pass_end && (rep_done || jump)) begin
            evt_d  = 1'b0;
            step_d = wrap ? 13'h0000 : nxt;
            st_d   = once ? wps_pkg::ST_IDLE : wps_pkg::ST_LOAD;
          end else if (pass_end) begin
            addr_d = ent_q.start;
            left_d = ent_q.len;
            rep_d  = ent_q.inf ? rep_q : rep_q - 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q   <= wps_pkg::ST_IDLE;
      step_q <= 13'h0000;
      addr_q <= 23'h00_0000;
      left_q <= 23'h00_0000;
      rep_q  <= 16'h0000;
      ent_q  <= '0;
      evt_q  <= 1'b0;
      infl_q <= 1'b0;
      dclk_o <= 1'b0;
    end else begin
      st_q   <= st_d;
      step_q <= step_d;
      addr_q <= addr_d;
      left_q <= left_d;
      rep_q  <= rep_d;
      ent_q  <= ent_d;
      evt_q  <= evt_d;
      infl_q <= issue & ~flush;
      dclk_o <= ~dclk_o;
    end
  end

  assign seq_wr = '{tgt: writedata_i[`WPS_Q_TGT], jmp: writedata_i[`WPS_Q_JMP],
                    wt: writedata_i[`WPS_Q_WAIT], inf: writedata_i[`WPS_Q_INF],
                    rep: writedata_i[`WPS_Q_REP], len: slen_q, start: ssta_q};

  wps_mem #(.W(SW), .D(`WPS_SEQ_DEPTH), .AW(`WPS_SEQ_AW)) u_seq (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .we_i    (w_sct),
    .waddr_i (sidx_q),
    .wdata_i (seq_wr),
    .re_i    (1'b1),
    .raddr_i (step_q),
    .rdata_o (seq_rd)
  );

  // Each word carries four samples and their markers together
  wps_mem #(.W(QW), .D(`WPS_MEM_DEPTH), .AW(`WPS_MEM_AW)) u_wave (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .we_i    (w_sdt & wmem_ok),
    .waddr_i (wadr_q),
    .wdata_i ({mdat_q, writedata_i}),
    .re_i    (issue),
    .raddr_i (addr_q),
    .rdata_o (rd_quad)
  );

  assign pop = quad_valid_o & quad_ready_i;

  wps_buf #(.W(QW)) u_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (flush),
    .in_valid_i  (infl_q),
    .in_ready_o  (bufrdy),
    .in_data_i   (rd_quad),
    .out_valid_o (quad_valid_o),
    .out_ready_i (quad_ready_i),
    .out_data_o  (quad_o),
    .count_o     (bcnt)
  );
endmodule

/* File: rtl/wps_defs.svh */
/*
  Constants of the waveform playback sequencer: timing, limits, register map and fields.
  Assumes a 200 MHz core clock and a 32-bit register bus.
*/
`ifndef WPS_DEFS_SVH
`define WPS_DEFS_SVH
`define WPS_CLK_NS     5
`define WPS_TICK_NS    100
`define WPS_TICK_CYC   ((`WPS_TICK_NS + `WPS_CLK_NS - 1) / `WPS_CLK_NS)
`define WPS_PER_MIN    27'h000_000A
`define WPS_PER_MAX    27'h5F5_E100
`define WPS_PER_RST    27'h000_2710
`define WPS_PTS_MIN    25'h000_03C0
`define WPS_PTS_BASE   25'h0F7_3140
`define WPS_PTS_OPT    25'h1EE_6280
`define WPS_Q_BASE     23'h03D_CC50
`define WPS_Q_OPT      23'h07B_98A0
`define WPS_MEM_DEPTH  32'h007B_98A0
`define WPS_SEQ_DEPTH  32'h0000_1F40
`define WPS_MEM_AW     23
`define WPS_SEQ_AW     13
`define WPS_SEQ_CNT_RST 13'h0001
`define WPS_A_CTRL     8'h00
`define WPS_A_STAT     8'h04
`define WPS_A_CMD      8'h08
`define WPS_A_PER      8'h0C
`define WPS_A_SCNT     8'h10
`define WPS_A_SIDX     8'h14
`define WPS_A_SSTA     8'h18
`define WPS_A_SLEN     8'h1C
`define WPS_A_SCTL     8'h20
`define WPS_A_WADR     8'h24
`define WPS_A_MDAT     8'h28
`define WPS_A_SDAT     8'h2C
`define WPS_C_MODE     1:0
`define WPS_C_RUN      2
`define WPS_C_ITRG     3
`define WPS_S_BUSY     0
`define WPS_S_WAIT     1
`define WPS_S_ERR      2
`define WPS_S_OPT      3
`define WPS_S_STEP     28:16
`define WPS_K_TRIG     0
`define WPS_Q_REP      15:0
`define WPS_Q_INF      16
`define WPS_Q_WAIT     17
`define WPS_Q_JMP      18
`define WPS_Q_TGT      31:19
`define WPS_P_TRIG     0
`define WPS_P_BTN      1
`define WPS_P_GATE     2
`define WPS_P_EVT      3
`define WPS_P_OPT      4
`define WPS_NPIN       5
`endif

/* File: rtl/wps_pkg.sv */
/*
  Types of the waveform playback sequencer.
  Assumes wps_defs.svh on the include path.
*/
`include "wps_defs.svh"
package wps_pkg;
  typedef enum logic [1:0] {WPS_CONT, WPS_TRIG, WPS_GATE, WPS_ENH} wps_mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_ARM, ST_WAIT, ST_PLAY} wps_state_t;
  typedef struct packed {
    logic [3:0][1:0] mrk;
    logic [3:0][7:0] smp;
  } wps_quad_t;
  typedef struct packed {
    logic [`WPS_SEQ_AW-1:0] tgt;
    logic                   jmp;
    logic                   wt;
    logic                   inf;
    logic [15:0]            rep;
    logic [`WPS_MEM_AW-1:0] len;
    logic [`WPS_MEM_AW-1:0] start;
  } wps_step_t;
endpackage

/* File: rtl/wps_mem.sv */
/*
  Simple dual-port memory, one write port and one registered read port.
  Assumes both ports on the core clock; contents are undefined until written.
*/
`timescale 1ns/1ps
`include "wps_defs.svh"
module wps_mem #(
  parameter int W  = 40,
  parameter int D  = `WPS_MEM_DEPTH,
  parameter int AW = `WPS_MEM_AW
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

/* File: rtl/wps_buf.sv */
/*
  Two-entry buffer with valid and ready on both sides; head word comes from a flop.
  Assumes flush_i discards both entries in one cycle.
*/
`timescale 1ns/1ps
module wps_buf #(
  parameter int W = 40
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o,
  output logic      [1:0]   count_o
);
  logic [W-1:0] e1_q;
  wire          push = in_valid_i & in_ready_o;
  wire          pop  = out_valid_o & out_ready_i;
  wire          to_head = (count_o == 2'h0) || (pop && count_o == 2'h1);

  assign in_ready_o  = (count_o != 2'h2);
  assign out_valid_o = (count_o != 2'h0);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= 2'h0;
    end else if (flush_i) begin
      count_o <= 2'h0;
    end else begin
      count_o <= count_o + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_data_o <= '0;
      e1_q       <= '0;
    end else begin
      if (push && to_head) begin
        out_data_o <= in_data_i;
      end else if (pop) begin
        out_data_o <= e1_q;
      end
      if (push && !to_head) begin
        e1_q <= in_data_i;
      end
    end
  end
endmodule

/* File: verification/wps_sink.sv */
/*
  Converter model: takes one quad per accepted cycle and can stall.
  Assumes the core clock and the stream port of the top.
*/
`timescale 1ns/1ps
module wps_sink (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               stall_i,
  input  wire wps_pkg::wps_quad_t quad_i,
  input  wire logic               valid_i,
  output logic                    ready_o
);
  wps_pkg::wps_quad_t got[$];
  logic [1:0]         ph;
  initial ph = 2'h0;
  initial ready_o = 1'b0;
  // Stalling takes one quad in four cycles
  always @(posedge clk_i) begin
    if (valid_i && ready_o) got.push_back(quad_i);
    ph <= ph + 2'h1;
    ready_o <= rst_n_i && !(stall_i && ph != 2'h0);
  end
endmodule

/* File: verification/wps_top_asserts.sv */
/*
  Port checker of the playback sequencer.
  Assumes binding to wps_top; tracks CTRL from accepted bus writes.
*/
`timescale 1ns/1ps
`include "wps_defs.svh"
module wps_top_asserts (
  input wire logic               clk_i,
  input wire logic               rst_n_i,
  input wire logic [7:0]         address_i,
  input wire logic               read_i,
  input wire logic               write_i,
  input wire logic [3:0]         byteenable_i,
  input wire logic [31:0]        writedata_i,
  input wire logic [31:0]        readdata_o,
  input wire logic               waitrequest_o,
  input wire logic               gate_i,
  input wire wps_pkg::wps_quad_t quad_o,
  input wire logic               quad_valid_o,
  input wire logic               quad_ready_i,
  input wire logic               dclk_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic       wr_ctrl;
  logic [1:0] mode_q;
  logic       run_q;
  logic [3:0] idle_q;
  assign wr_ctrl = write_i && !waitrequest_o && address_i == `WPS_A_CTRL
                   && byteenable_i == 4'hF;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= 2'h0;
      run_q  <= 1'b0;
    end else if (wr_ctrl) begin
      mode_q <= writedata_i[`WPS_C_MODE];
      run_q  <= writedata_i[`WPS_C_RUN];
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) idle_q <= 4'h0;
    else if (run_q) idle_q <= 4'h0;
    else if (idle_q != 4'hF) idle_q <= idle_q + 4'h1;
  end
  sequence s_req;
    (read_i || write_i) && waitrequest_o;
  endsequence
  sequence s_ack;
    !waitrequest_o;
  endsequence
  sequence s_shut;
    run_q && mode_q == 2'h2 && !gate_i;
  endsequence
  AST_BUS_ONE_WAIT: assert property (s_req |=> s_ack)
    else $error("bus wait not one cycle");
  AST_BUS_IDLE: assert property (!(read_i || write_i) |-> !waitrequest_o)
    else $error("waitrequest without request");
  AST_UNMAPPED_ZERO: assert property (read_i && !waitrequest_o && address_i > 8'h2C
    |-> readdata_o == 32'h0000_0000) else $error("unmapped read not zero");
  AST_DCLK_RUNS: assert property (1'b1 |=> dclk_o != $past(dclk_o))
    else $error("data clock stopped");
  AST_QUAD_HOLD: assert property (quad_valid_o && !quad_ready_i
    |=> !quad_valid_o || $stable(quad_o)) else $error("quad changed while stalled");
  AST_STOP_FLUSH: assert property (wr_ctrl && !writedata_i[`WPS_C_RUN]
    |-> ##[1:3] !quad_valid_o) else $error("stop left data");
  AST_GATE_SHUT: assert property (s_shut [*8] |-> !quad_valid_o)
    else $error("play with gate closed");
  AST_IDLE_QUIET: assert property (idle_q == 4'hF |-> !quad_valid_o)
    else $error("data while stopped");
  AST_CONT_FLOW: assert property (run_q && mode_q == 2'h0 && !wr_ctrl && quad_valid_o
    && quad_ready_i |-> ##[1:4] quad_valid_o) else $error("continuous play paused");
endmodule
bind wps_top wps_top_asserts u_wps_top_asserts (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .byteenable_i(byteenable_i), .writedata_i(writedata_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .gate_i(gate_i),
  .quad_o(quad_o), .quad_valid_o(quad_valid_o), .quad_ready_i(quad_ready_i),
  .dclk_o(dclk_o));

/* File: verification/wps_top_tb.sv */
/*
  Self-checking bench of the playback sequencer.
  Assumes wps_top, wps_sink and the checker are compiled before it.
*/
`timescale 1ns/1ps
`include "wps_defs.svh"
module wps_top_tb;
  logic               clk_i, rst_n_i, read_i, write_i, trig_pin_i, trig_btn_i;
  logic               gate_i, event_i, mem_opt_i, stall, quad_valid_o, quad_ready_i;
  logic               waitrequest_o, dclk_o;
  logic [7:0]         address_i;
  logic [3:0]         byteenable_i;
  logic [31:0]        writedata_i, readdata_o;
  wps_pkg::wps_quad_t quad_o;
  int                 n_errors, num_checks;
  logic [7:0]         ba[5] = '{`WPS_A_SLEN, `WPS_A_SLEN, `WPS_A_SLEN, `WPS_A_PER, `WPS_A_PER};
  logic [31:0]        bd[5] = '{32'h0000_03C2, 32'h0000_03BC, 32'h00F7_3144,
                                32'h0000_0009, 32'h05F5_E101};
  wps_top u_wps_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .byteenable_i(byteenable_i),
    .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .trig_pin_i(trig_pin_i), .trig_btn_i(trig_btn_i), .gate_i(gate_i), .event_i(event_i),
    .mem_opt_i(mem_opt_i), .quad_o(quad_o), .quad_valid_o(quad_valid_o),
    .quad_ready_i(quad_ready_i), .dclk_o(dclk_o));
  wps_sink u_wps_sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .stall_i(stall), .quad_i(quad_o),
    .valid_i(quad_valid_o), .ready_o(quad_ready_i));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  function automatic wps_pkg::wps_quad_t mk(input int p);
    return {8'(p) ^ 8'h5A, 8'(4 * p + 3), 8'(4 * p + 2), 8'(4 * p + 1), 8'(4 * p)};
  endfunction
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= d;
    read_i <= rd;
    write_i <= !rd;
    do @(posedge clk_i); while (waitrequest_o !== 1'b0);
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask
  task automatic cr(input string s, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] q;
    bus(1'b1, a, 32'h0000_0000, q);
    num_checks++;
    if ((q & m) !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", s, e, q & m);
    end
  endtask
  task automatic cq(input int i, input wps_pkg::wps_quad_t e, input wps_pkg::wps_quad_t g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] quad %0d exp %h got %h", i, e, g);
    end
  endtask
  task automatic cn(input string s, input int e);
    num_checks++;
    if (u_wps_sink.got.size() != e) begin
      n_errors++;
      $display("[FAIL] %s exp %0d got %0d", s, e, u_wps_sink.got.size());
    end
  endtask
  task automatic cb(input string s, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %b got %b", s, e, g);
    end
  endtask
  task automatic see(input int n);
    int p;
    while (u_wps_sink.got.size() < n) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      p = i % 720;
      p = p < 480 ? p % 240 : p - 240;
      cq(i, mk(p), u_wps_sink.got[i]);
    end
  endtask
  task automatic clr;
    repeat (20) @(posedge clk_i);
    u_wps_sink.got.delete();
  endtask
  task automatic st(input int i, input int s, input logic [31:0] c);
    wr(`WPS_A_SIDX, 32'(i));
    wr(`WPS_A_SSTA, 32'(s));
    wr(`WPS_A_SLEN, 32'h0000_03C0);
    wr(`WPS_A_SCTL, c);
  endtask
  task automatic trg(input int k);
    if (k == 2) wr(`WPS_A_CMD, 32'h0000_0001);
    else begin
      @(posedge clk_i);
      if (k == 0) trig_pin_i <= 1'b1;
      else trig_btn_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      trig_pin_i <= 1'b0;
      trig_btn_i <= 1'b0;
    end
  endtask
  task automatic t_limits;
    cr("per", `WPS_A_PER, 32'hFFFF_FFFF, 32'h0000_2710);
    cr("scnt", `WPS_A_SCNT, 32'hFFFF_FFFF, 32'h0000_0001);
    for (int k = 0; k < 5; k++) begin
      wr(ba[k], bd[k]);
      cr("err", `WPS_A_STAT, 32'h0000_0004, 32'h0000_0004);
      wr(`WPS_A_STAT, 32'h0000_0004);
    end
    wr(`WPS_A_PER, 32'h0000_000A);
    cr("per min", `WPS_A_STAT, 32'h0000_0004, 32'h0000_0000);
    byteenable_i <= 4'h3;
    wr(`WPS_A_PER, 32'h0000_0014);
    byteenable_i <= 4'hF;
    cr("partial", `WPS_A_PER, 32'hFFFF_FFFF, 32'h0000_000A);
    mem_opt_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    wr(`WPS_A_SLEN, bd[2]);
    cr("opt", `WPS_A_STAT, 32'h0000_000C, 32'h0000_0008);
    mem_opt_i <= 1'b0;
    cr("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask
  task automatic t_load;
    wps_pkg::wps_quad_t v;
    wr(`WPS_A_WADR, 32'h0000_0000);
    for (int q = 0; q < 480; q++) begin
      v = mk(q);
      wr(`WPS_A_MDAT, {24'h00_0000, v.mrk});
      wr(`WPS_A_SDAT, v.smp);
    end
    st(0, 0, 32'h0000_0001);
    st(1, 240, 32'h0000_0000);
    wr(`WPS_A_SCNT, 32'h0000_0002);
  endtask
  task automatic t_cont;
    stall <= 1'b1;
    wr(`WPS_A_CTRL, 32'h0000_0004);
    see(1500);
    wr(`WPS_A_CTRL, 32'h0000_0000);
    stall <= 1'b0;
    clr();
  endtask
  task automatic t_trig;
    wr(`WPS_A_CTRL, 32'h0000_0005);
    repeat (60) @(posedge clk_i);
    cn("no trigger", 0);
    for (int k = 0; k < 3; k++) begin
      trg(k);
      while (u_wps_sink.got.size() < 200) @(posedge clk_i);
      trg((k + 1) % 3);
      while (u_wps_sink.got.size() < 720) @(posedge clk_i);
      repeat (100) @(posedge clk_i);
      cn("one pass", 720);
      see(720);
      u_wps_sink.got.delete();
    end
    wr(`WPS_A_CTRL, 32'h0000_000D);
    repeat (150) @(posedge clk_i);
    cn("timer wait", 0);
    see(720);
    wr(`WPS_A_CTRL, 32'h0000_0000);
    clr();
  endtask
  task automatic t_gate;
    logic d;
    wr(`WPS_A_CTRL, 32'h0000_0006);
    repeat (60) @(posedge clk_i);
    cn("gate shut", 0);
    gate_i <= 1'b1;
    see(300);
    gate_i <= 1'b0;
    clr();
    repeat (30) @(posedge clk_i);
    d = dclk_o;
    @(posedge clk_i);
    cb("dclk", !d, dclk_o);
    cn("gate shut", 0);
    gate_i <= 1'b1;
    see(20);
    gate_i <= 1'b0;
    wr(`WPS_A_CTRL, 32'h0000_0000);
    clr();
  endtask
  task automatic t_enh;
    st(0, 0, 32'h0002_0001);
    wr(`WPS_A_CTRL, 32'h0000_0007);
    repeat (60) @(posedge clk_i);
    cn("step wait", 0);
    cr("waiting", `WPS_A_STAT, 32'h0000_0002, 32'h0000_0002);
    trg(0);
    see(20);
    wr(`WPS_A_CTRL, 32'h0000_0000);
    clr();
    wr(`WPS_A_CTRL, 32'h0000_0004);
    see(20);
    wr(`WPS_A_CTRL, 32'h0000_0000);
    clr();
    st(0, 0, 32'h000C_0001);
    wr(`WPS_A_CTRL, 32'h0000_0007);
    while (u_wps_sink.got.size() < 10) @(posedge clk_i);
    event_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    event_i <= 1'b0;
    while (u_wps_sink.got.size() < 480) @(posedge clk_i);
    for (int i = 0; i < 480; i++) begin
      cq(i, mk(i), u_wps_sink.got[i]);
    end
    wr(`WPS_A_CTRL, 32'h0000_0000);
    clr();
  endtask
  initial begin
    {rst_n_i, read_i, write_i, trig_pin_i, trig_btn_i, gate_i, event_i} = 7'h00;
    {mem_opt_i, stall} = 2'h0;
    address_i = 8'h00;
    byteenable_i = 4'hF;
    writedata_i = 32'h0000_0000;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_limits();
    t_load();
    t_cont();
    t_trig();
    t_gate();
    t_enh();
    final_report();
  end
  initial begin
    #300000;
    n_errors++;
    final_report();
  end
endmodule
